// ---- rtl/pbc_pkg.sv ----
// Package of constants for the port B / port C alternate function override block.
// Behaviour
// - Serial interface enabled as slave forces the MOSI pin to input.
// - Serial interface enabled as master lets MOSI direction follow its direction bit.
// - Serial interface enabled as slave forces the SCK pin to input.
// - Serial interface enabled as master lets SCK direction follow its direction bit.
// - Serial interface enabled as slave forces the SS pin to input.
// - As slave the serial interface is active only while SS is held low.
// - As master SS direction follows its bit and SS value is never overridden.
// - A forced input keeps its pull-up from the output latch, gated by pull-up disable.
// - MISO carries slave output data and its input feeds the master receive path.
// - MOSI carries master output data and its input feeds the slave receive path.
// - Upper port B pins take compare outputs as value only, when that compare is enabled.
// - Legacy mode removes timer1 compare C, so the top pin carries only timer2.
// - Legacy mode makes every port C pin an output.
// - Port C pins carry external address bits 15 down to 8, highest to highest.
// - Port C pins 7 to 4 become address when enabled and mask is below 1..4.
// - Port C pins 3,2 use mask below 5,6; pins 1,0 use mask below 7.
// - Legacy mode treats the high-address mask as zero.
// - Serial interface enabled as master forces the MISO pin to input.
package pbc_pkg;
  localparam int PORT_W = 8;
  localparam int MASK_W = 3;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  // Register byte addresses.
  localparam logic [WB_AW-1:0] REG_PB_LATCH = 8'h00;
  localparam logic [WB_AW-1:0] REG_PB_DIR = 8'h04;
  localparam logic [WB_AW-1:0] REG_PC_LATCH = 8'h08;
  localparam logic [WB_AW-1:0] REG_PC_DIR = 8'h0C;
  localparam logic [WB_AW-1:0] REG_CTRL = 8'h10;
  localparam logic [WB_AW-1:0] REG_PB_PINS = 8'h14;
  localparam logic [WB_AW-1:0] REG_PC_PINS = 8'h18;
  localparam logic [WB_AW-1:0] REG_DIR_STATE = 8'h1C;

  // Control register fields.
  localparam int CTL_SERIAL_EN = 0;
  localparam int CTL_MASTER = 1;
  localparam int CTL_EXT_MEM_EN = 2;
  localparam int CTL_MASK_LSB = 3;
  localparam int CTL_PUD = 6;
  localparam int CTL_W = 7;

  localparam logic [PORT_W-1:0] RST_PORT = 8'h00;
  localparam logic [CTL_W-1:0] RST_CTRL = 7'h00;

  // Port B pin positions.
  localparam int PB_SS = 0;
  localparam int PB_SCK = 1;
  localparam int PB_MOSI = 2;
  localparam int PB_MISO = 3;
  localparam int PB_OC0 = 4;
  localparam int PB_TIMER1_COMPARE_A_OUT = 5;
  localparam int PB_TIMER1_COMPARE_B_OUT = 6;
  localparam int PB_OC2 = 7;

  // Per port C pin, the mask value below which the pin carries address; pin 7 is the top nibble.
  localparam logic [4*PORT_W-1:0] MASK_LIMITS = 32'h1234_5677;
endpackage

// ---- rtl/pbc_pin_resolve.sv ----
// One pin's override resolver: merges port settings with peripheral overrides.
`timescale 1ns/1ps
module pbc_pin_resolve (
  input wire logic latch_i,
  input wire logic dir_i,
  input wire logic pud_i,
  input wire logic pullup_override_enable_i,
  input wire logic pullup_override_value_i,
  input wire logic direction_override_enable_i,
  input wire logic direction_override_value_i,
  input wire logic output_value_override_enable_i,
  input wire logic output_value_override_value_i,
  output logic pullup_o,
  output logic drive_o,
  output logic value_o
);
  wire plain_pullup = latch_i & ~dir_i & ~pud_i;

  // Each override selects independently of the other two.
  assign pullup_o = pullup_override_enable_i ? pullup_override_value_i : plain_pullup;
  assign drive_o = direction_override_enable_i ? direction_override_value_i : dir_i;
  assign value_o = output_value_override_enable_i ? output_value_override_value_i : latch_i;
endmodule

// ---- rtl/pbc_port_override.sv ----
// Port B and port C alternate function override with a classic Wishbone register slave.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module pbc_port_override (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pbc_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pbc_pkg::WB_DW-1:0] wb_dat_i,
  output logic [pbc_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic legacy_mode_i,
  input wire logic serial_slave_out_i,
  input wire logic serial_master_out_i,
  input wire logic serial_clock_out_i,
  output logic serial_master_in_o,
  output logic serial_slave_in_o,
  output logic serial_clock_in_o,
  output logic serial_select_n_o,
  output logic serial_slave_active_o,
  input wire logic timer0_compare_en_i,
  input wire logic timer0_compare_out_i,
  input wire logic timer1_compare_a_en_i,
  input wire logic timer1_compare_a_out_i,
  input wire logic timer1_compare_b_en_i,
  input wire logic timer1_compare_b_out_i,
  input wire logic timer1_compare_c_en_i,
  input wire logic timer1_compare_c_out_i,
  input wire logic timer2_compare_en_i,
  input wire logic timer2_compare_out_i,
  input wire logic [pbc_pkg::PORT_W-1:0] ext_mem_addr_hi_i,
  input wire logic [pbc_pkg::PORT_W-1:0] pb_i,
  output logic [pbc_pkg::PORT_W-1:0] pb_o,
  output logic [pbc_pkg::PORT_W-1:0] pb_oe_o,
  output logic [pbc_pkg::PORT_W-1:0] pb_pullup_o,
  input wire logic [pbc_pkg::PORT_W-1:0] pc_i,
  output logic [pbc_pkg::PORT_W-1:0] pc_o,
  output logic [pbc_pkg::PORT_W-1:0] pc_oe_o,
  output logic [pbc_pkg::PORT_W-1:0] pc_pullup_o
);
  import pbc_pkg::*;

  logic [PORT_W-1:0] pb_latch_r;
  logic [PORT_W-1:0] pb_dir_r;
  logic [PORT_W-1:0] pc_latch_r;
  logic [PORT_W-1:0] pc_dir_r;
  logic [CTL_W-1:0] ctrl_r;
  logic [PORT_W-1:0] pb_meta_r;
  logic [PORT_W-1:0] pb_sync_r;
  logic [PORT_W-1:0] pc_meta_r;
  logic [PORT_W-1:0] pc_sync_r;
  logic ack_r;
  logic [WB_DW-1:0] rdata_r;

  // Bus decode.
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_pb_latch = wb_adr_i == REG_PB_LATCH;
  wire hit_pb_dir = wb_adr_i == REG_PB_DIR;
  wire hit_pc_latch = wb_adr_i == REG_PC_LATCH;
  wire hit_pc_dir = wb_adr_i == REG_PC_DIR;
  wire hit_ctrl = wb_adr_i == REG_CTRL;
  wire hit_pb_pins = wb_adr_i == REG_PB_PINS;
  wire hit_pc_pins = wb_adr_i == REG_PC_PINS;
  wire hit_dir_state = wb_adr_i == REG_DIR_STATE;

  // Control fields.
  wire serial_if_enable = ctrl_r[CTL_SERIAL_EN];
  wire master_role_select = ctrl_r[CTL_MASTER];
  wire ext_mem_enable = ctrl_r[CTL_EXT_MEM_EN];
  wire global_pullup_disable = ctrl_r[CTL_PUD];
  wire [MASK_W-1:0] ext_mem_high_mask = ctrl_r[CTL_MASK_LSB +: MASK_W];
  // Legacy mode reads the mask as zero, so every pin follows the memory enable.
  wire [MASK_W-1:0] mask_eff = legacy_mode_i ? '0 : ext_mem_high_mask;
  wire serial_master = serial_if_enable & master_role_select;
  wire serial_slave = serial_if_enable & ~master_role_select;

  // Port B override vectors.
  logic [PORT_W-1:0] pb_pue;
  logic [PORT_W-1:0] pb_puv;
  logic [PORT_W-1:0] pb_dde;
  logic [PORT_W-1:0] pb_pve;
  logic [PORT_W-1:0] pb_pvv;
  logic [PORT_W-1:0] pb_pull_nxt;
  logic [PORT_W-1:0] pb_oe_nxt;
  logic [PORT_W-1:0] pb_o_nxt;

  // Timer1 compare C does not exist in legacy mode; when both top compares run, either drives.
  wire t1c_active = timer1_compare_c_en_i & ~legacy_mode_i;
  wire top_pin_en = timer2_compare_en_i | t1c_active;
  wire top_pin_val = (timer2_compare_en_i & timer2_compare_out_i) |
                     (t1c_active & timer1_compare_c_out_i);

  // The serial pins that the role makes inputs: MISO as master, the other three as slave.
  wire [3:0] serial_forced = {serial_master, serial_slave, serial_slave, serial_slave};

  // Forced inputs keep a pull-up from the latch unless pull-ups are globally off.
  assign pb_pue = {4'h0, serial_forced};
  assign pb_puv = {4'h0, pb_latch_r[3:0] & {4{~global_pullup_disable}}};
  // Direction override value is always input, so only the enable matters.
  assign pb_dde = {4'h0, serial_forced};
  // MISO drives slave data as slave; MOSI and SCK drive as master; SS never takes a value.
  assign pb_pve = {top_pin_en,
                   timer1_compare_b_en_i,
                   timer1_compare_a_en_i,
                   timer0_compare_en_i,
                   serial_slave,
                   serial_master,
                   serial_master,
                   1'b0};
  assign pb_pvv = {top_pin_val,
                   timer1_compare_b_out_i,
                   timer1_compare_a_out_i,
                   timer0_compare_out_i,
                   serial_slave_out_i,
                   serial_master_out_i,
                   serial_clock_out_i,
                   1'b0};

  // Port C: address override per pin against its mask limit.
  logic [PORT_W-1:0] pc_addr_ovr;
  logic [PORT_W-1:0] pc_dde;
  logic [PORT_W-1:0] pc_ddv;
  logic [PORT_W-1:0] pc_pull_nxt;
  logic [PORT_W-1:0] pc_oe_nxt;
  logic [PORT_W-1:0] pc_o_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      wire [3:0] limit = MASK_LIMITS[4*gi +: 4];
      assign pc_addr_ovr[gi] = ext_mem_enable & ({1'b0, mask_eff} < limit);
      // Legacy mode turns the whole port into outputs, address or not.
      assign pc_dde[gi] = pc_addr_ovr[gi] | legacy_mode_i;
      assign pc_ddv[gi] = 1'b1;

      pbc_pin_resolve u_pb (
        .latch_i(pb_latch_r[gi]),
        .dir_i(pb_dir_r[gi]),
        .pud_i(global_pullup_disable),
        .pullup_override_enable_i(pb_pue[gi]),
        .pullup_override_value_i(pb_puv[gi]),
        .direction_override_enable_i(pb_dde[gi]),
        .direction_override_value_i(1'b0),
        .output_value_override_enable_i(pb_pve[gi]),
        .output_value_override_value_i(pb_pvv[gi]),
        .pullup_o(pb_pull_nxt[gi]),
        .drive_o(pb_oe_nxt[gi]),
        .value_o(pb_o_nxt[gi])
      );

      // Address pins take bit 8+gi of the address, so pin 7 carries the top bit.
      pbc_pin_resolve u_pc (
        .latch_i(pc_latch_r[gi]),
        .dir_i(pc_dir_r[gi]),
        .pud_i(global_pullup_disable),
        .pullup_override_enable_i(pc_dde[gi]),
        .pullup_override_value_i(1'b0),
        .direction_override_enable_i(pc_dde[gi]),
        .direction_override_value_i(pc_ddv[gi]),
        .output_value_override_enable_i(pc_addr_ovr[gi]),
        .output_value_override_value_i(ext_mem_addr_hi_i[gi]),
        .pullup_o(pc_pull_nxt[gi]),
        .drive_o(pc_oe_nxt[gi]),
        .value_o(pc_o_nxt[gi])
      );
    end
  endgenerate

  // Read mux.
  wire [PORT_W-1:0] rd_byte = hit_pb_latch ? pb_latch_r :
                              hit_pb_dir ? pb_dir_r :
                              hit_pc_latch ? pc_latch_r :
                              hit_pc_dir ? pc_dir_r :
                              hit_ctrl ? {1'b0, ctrl_r} :
                              hit_pb_pins ? pb_sync_r :
                              hit_pc_pins ? pc_sync_r : 8'h00;
  wire [WB_DW-1:0] rd_word = hit_dir_state ? {16'h0000, pc_oe_o, pb_oe_o} :
                                             {24'h00_0000, rd_byte};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= wb_req;
      rdata_r <= wb_req ? rd_word : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_latch_r <= RST_PORT;
      pb_dir_r <= RST_PORT;
      pc_latch_r <= RST_PORT;
      pc_dir_r <= RST_PORT;
      ctrl_r <= RST_CTRL;
    end else if (wb_wr) begin
      if (hit_pb_latch) pb_latch_r <= wb_dat_i[PORT_W-1:0];
      if (hit_pb_dir) pb_dir_r <= wb_dat_i[PORT_W-1:0];
      if (hit_pc_latch) pc_latch_r <= wb_dat_i[PORT_W-1:0];
      if (hit_pc_dir) pc_dir_r <= wb_dat_i[PORT_W-1:0];
      if (hit_ctrl) ctrl_r <= wb_dat_i[CTL_W-1:0];
    end
  end

  // Pins are asynchronous to the core, so every input crosses two flops first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_meta_r <= RST_PORT;
      pb_sync_r <= RST_PORT;
      pc_meta_r <= RST_PORT;
      pc_sync_r <= RST_PORT;
    end else begin
      pb_meta_r <= pb_i;
      pb_sync_r <= pb_meta_r;
      pc_meta_r <= pc_i;
      pc_sync_r <= pc_meta_r;
    end
  end

  // Pin drives are registered so the pads never see decode glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_o <= RST_PORT;
      pb_oe_o <= RST_PORT;
      pb_pullup_o <= RST_PORT;
      pc_o <= RST_PORT;
      pc_oe_o <= RST_PORT;
      pc_pullup_o <= RST_PORT;
    end else begin
      pb_o <= pb_o_nxt;
      pb_oe_o <= pb_oe_nxt;
      pb_pullup_o <= pb_pull_nxt;
      pc_o <= pc_o_nxt;
      pc_oe_o <= pc_oe_nxt;
      pc_pullup_o <= pc_pull_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign serial_master_in_o = pb_sync_r[PB_MISO];
  assign serial_slave_in_o = pb_sync_r[PB_MOSI];
  assign serial_clock_in_o = pb_sync_r[PB_SCK];
  assign serial_select_n_o = pb_sync_r[PB_SS];
  // A slave only takes part while the far master holds select low.
  assign serial_slave_active_o = serial_slave & ~pb_sync_r[PB_SS];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wb_ack;
    s_wb_req |=> s_wb_answer;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus ack not one cycle after request");

  property p_mosi_slave_in;
    serial_slave |=> !pb_oe_o[PB_MOSI];
  endproperty
  a_mosi_slave_in: assert property (p_mosi_slave_in) else $error("MOSI driven as slave");

  property p_mosi_master_dir;
    serial_master |=> pb_oe_o[PB_MOSI] == $past(pb_dir_r[PB_MOSI]);
  endproperty
  a_mosi_master_dir: assert property (p_mosi_master_dir) else $error("MOSI dir wrong");

  property p_sck_slave_in;
    serial_slave |=> !pb_oe_o[PB_SCK];
  endproperty
  a_sck_slave_in: assert property (p_sck_slave_in) else $error("SCK driven as slave");

  property p_sck_master;
    serial_master |=> pb_oe_o[PB_SCK] == $past(pb_dir_r[PB_SCK]) &&
                      pb_o[PB_SCK] == $past(serial_clock_out_i);
  endproperty
  a_sck_master: assert property (p_sck_master) else $error("SCK master path wrong");

  property p_ss_slave_in;
    serial_slave |=> !pb_oe_o[PB_SS];
  endproperty
  a_ss_slave_in: assert property (p_ss_slave_in) else $error("SS driven as slave");

  property p_slave_active;
    serial_slave_active_o |-> serial_slave && !$past(pb_i[PB_SS], 2);
  endproperty
  a_slave_active: assert property (p_slave_active) else $error("Slave active without SS low");

  property p_ss_master;
    serial_master |=> pb_o[PB_SS] == $past(pb_latch_r[PB_SS]) &&
                      pb_oe_o[PB_SS] == $past(pb_dir_r[PB_SS]);
  endproperty
  a_ss_master: assert property (p_ss_master) else $error("SS overridden as master");

  property p_forced_pullup;
    serial_slave |=> pb_pullup_o[PB_MOSI] ==
                     $past(pb_latch_r[PB_MOSI] & ~global_pullup_disable);
  endproperty
  a_forced_pullup: assert property (p_forced_pullup) else $error("Forced input pull-up wrong");

  property p_miso_slave_out;
    serial_slave |=> pb_o[PB_MISO] == $past(serial_slave_out_i);
  endproperty
  a_miso_slave_out: assert property (p_miso_slave_out) else $error("MISO slave data wrong");

  property p_mosi_master_out;
    serial_master |=> pb_o[PB_MOSI] == $past(serial_master_out_i);
  endproperty
  a_mosi_master_out: assert property (p_mosi_master_out) else $error("MOSI data wrong");

  // Inputs that reset leaves alone are only trusted once the release edge has passed.
  property p_oc0_value;
    !rst_i && timer0_compare_en_i |=> pb_o[PB_OC0] == $past(timer0_compare_out_i) &&
                            pb_oe_o[PB_OC0] == $past(pb_dir_r[PB_OC0]);
  endproperty
  a_oc0_value: assert property (p_oc0_value) else $error("Compare 0 override wrong");

  property p_legacy_top_pin;
    !rst_i && legacy_mode_i && timer2_compare_en_i |=>
      pb_o[PB_OC2] == $past(timer2_compare_out_i);
  endproperty
  a_legacy_top_pin: assert property (p_legacy_top_pin) else $error("Top pin not timer2");

  property p_legacy_pc_out;
    !rst_i && legacy_mode_i |=> pc_oe_o == 8'hFF;
  endproperty
  a_legacy_pc_out: assert property (p_legacy_pc_out) else $error("Port C not output");

  property p_addr_top;
    ext_mem_enable && mask_eff == 3'h0 |=> pc_o == $past(ext_mem_addr_hi_i);
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("Address byte not on port C");

  property p_mask_pin4;
    ext_mem_enable && mask_eff == 3'h4 |=> pc_o[4] == $past(pc_latch_r[4]) &&
                                           pc_o[3] == $past(ext_mem_addr_hi_i[3]);
  endproperty
  a_mask_pin4: assert property (p_mask_pin4) else $error("Mask 4 boundary wrong");

  property p_mask_pin0;
    ext_mem_enable && mask_eff == 3'h6 |=> pc_o[0] == $past(ext_mem_addr_hi_i[0]) &&
                                           pc_o[2] == $past(pc_latch_r[2]);
  endproperty
  a_mask_pin0: assert property (p_mask_pin0) else $error("Mask 6 boundary wrong");

  property p_legacy_mask;
    legacy_mode_i && ext_mem_enable |=> pc_o == $past(ext_mem_addr_hi_i);
  endproperty
  a_legacy_mask: assert property (p_legacy_mask) else $error("Legacy mask not zero");

  property p_miso_master_in;
    serial_master |=> !pb_oe_o[PB_MISO];
  endproperty
  a_miso_master_in: assert property (p_miso_master_in) else $error("MISO driven as master");

  property p_addr_pin_drive;
    pc_addr_ovr[7] |=> pc_oe_o[7] && !pc_pullup_o[7];
  endproperty
  a_addr_pin_drive: assert property (p_addr_pin_drive) else $error("Address pin not output");

  property p_plain_pins;
    !serial_if_enable |=> pb_oe_o[3:0] == $past(pb_dir_r[3:0]) &&
                          pb_o[3:0] == $past(pb_latch_r[3:0]);
  endproperty
  a_plain_pins: assert property (p_plain_pins) else $error("Plain port path wrong");
endmodule

// ---- test/pbc_periph_model.sv ----
// Behavioural model of the timers, serial interface and memory interface feeding the block.
`timescale 1ns/1ps
module pbc_periph_model (
  input wire logic clk_i,
  input wire logic [31:0] rnd_i,
  output logic [2:0] serial_o,
  output logic [4:0] cmp_en_o,
  output logic [4:0] cmp_out_o,
  output logic [7:0] addr_hi_o
);
  initial begin
    serial_o = 3'h0;
    cmp_en_o = 5'h00;
    cmp_out_o = 5'h00;
    addr_hi_o = 8'h00;
  end
  // Outputs hold on about half the cycles, so slow and quick peripherals both show up.
  always @(posedge clk_i) begin
    if (rnd_i[31]) begin
      serial_o <= rnd_i[30:28];
      cmp_en_o <= rnd_i[27:23];
      cmp_out_o <= rnd_i[22:18];
      addr_hi_o <= rnd_i[17:10];
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the port B and port C override block.
`timescale 1ns/1ps
module tb_top;
  import pbc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic legacy = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rnd = 32'h23;
  logic [31:0] rdat;
  logic ack, mi, si, ci, ssn, act;
  logic [7:0] pb_o, pb_oe, pb_pu, pc_o, pc_oe, pc_pu, pb_i, pc_i, ad_hi;
  logic [2:0] sp;
  logic [4:0] ten, tout;
  logic [7:0] sh_lb, sh_db, sh_lc, sh_dc, hist;
  logic [6:0] sh_ctrl;
  logic [47:0] ex;
  logic [3:0] ein;
  int arm = 0;
  int fail_count = 0;
  int checks_done = 0;

  pbc_port_override u_pbc_port_override (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .legacy_mode_i(legacy), .serial_slave_out_i(sp[2]),
    .serial_master_out_i(sp[1]), .serial_clock_out_i(sp[0]), .serial_master_in_o(mi),
    .serial_slave_in_o(si), .serial_clock_in_o(ci), .serial_select_n_o(ssn),
    .serial_slave_active_o(act), .timer0_compare_en_i(ten[0]), .timer0_compare_out_i(tout[0]),
    .timer1_compare_a_en_i(ten[1]), .timer1_compare_a_out_i(tout[1]),
    .timer1_compare_b_en_i(ten[2]), .timer1_compare_b_out_i(tout[2]),
    .timer1_compare_c_en_i(ten[4]), .timer1_compare_c_out_i(tout[4]),
    .timer2_compare_en_i(ten[3]), .timer2_compare_out_i(tout[3]), .ext_mem_addr_hi_i(ad_hi),
    .pb_i(pb_i), .pb_o(pb_o), .pb_oe_o(pb_oe), .pb_pullup_o(pb_pu), .pc_i(pc_i), .pc_o(pc_o),
    .pc_oe_o(pc_oe), .pc_pullup_o(pc_pu));
  pbc_periph_model u_pbc_periph_model (.clk_i(clk_i), .rnd_i(rnd), .serial_o(sp),
    .cmp_en_o(ten), .cmp_out_o(tout), .addr_hi_o(ad_hi));

  // An undriven line takes a random pattern, biased high when pulled up; the far master drives SS at will.
  assign pb_i = (pb_oe & pb_o) | (~pb_oe & (rnd[15:8] | (~rnd[7:0] & pb_pu)));
  assign pc_i = (pc_oe & pc_o) | (~pc_oe & (rnd[23:16] | (~rnd[7:0] & pc_pu)));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [47:0] exp_pins();
    logic [7:0] bo, be, bp, co, ce, cp;
    logic [31:0] lim;
    logic [2:0] mk;
    logic pd;
    int k;
    lim = 32'h1234_5677;
    pd = sh_ctrl[6];
    mk = legacy ? 3'h0 : sh_ctrl[5:3];
    bo = sh_lb;
    be = sh_db;
    bp = sh_lb & ~sh_db & {8{~pd}};
    if (sh_ctrl[0] && !sh_ctrl[1]) begin
      be[2:0] = 3'h0;
      bp[2:0] = sh_lb[2:0] & {3{~pd}};
      bo[3] = sp[2];
    end
    if (sh_ctrl[0] && sh_ctrl[1]) begin
      be[3] = 1'b0;
      bp[3] = sh_lb[3] & ~pd;
      bo[2] = sp[1];
      bo[1] = sp[0];
    end
    for (k = 4; k < 7; k++) begin
      if (ten[k-4]) bo[k] = tout[k-4];
    end
    if (ten[3] || (ten[4] && !legacy)) begin
      bo[7] = (ten[3] & tout[3]) | (ten[4] & tout[4] & ~legacy);
    end
    co = sh_lc;
    ce = legacy ? 8'hFF : sh_dc;
    cp = legacy ? 8'h00 : sh_lc & ~sh_dc & {8{~pd}};
    for (k = 0; k < 8; k++) begin
      if (sh_ctrl[2] && ({1'b0, mk} < lim[4*k+:4])) begin
        co[k] = ad_hi[k];
        ce[k] = 1'b1;
        cp[k] = 1'b0;
      end
    end
    return {bo, be, bp, co, ce, cp};
  endfunction

  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: pins got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk_word({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic stop_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) rnd <= xs(rnd);

  // Shadow registers follow each write at the edge that the slave takes it.
  always @(posedge clk_i) begin
    ex = exp_pins();
    ein = hist[3:0];
    hist = pb_i;
    if (rst_i) begin
      {sh_lb, sh_db, sh_lc, sh_dc} <= 32'h0;
      sh_ctrl <= 7'h00;
      arm <= 0;
      #1;
      chk_pin(pb_o | pb_oe | pb_pu | pc_o | pc_oe | pc_pu, 8'h00);
    end else begin
      if (arm < 3) arm <= arm + 1;
      if (cyc && stb && we && ack !== 1'b1 && sel[0]) begin
        case (adr)
          REG_PB_LATCH: sh_lb <= wdat[7:0];
          REG_PB_DIR: sh_db <= wdat[7:0];
          REG_PC_LATCH: sh_lc <= wdat[7:0];
          REG_PC_DIR: sh_dc <= wdat[7:0];
          REG_CTRL: sh_ctrl <= wdat[6:0];
          default: ;
        endcase
      end
      // Drives are checked from the first edge after reset; pin inputs from two edges later.
      #1;
      chk_pin(pb_o & ex[39:32], ex[47:40] & ex[39:32]);
      chk_pin(pb_oe, ex[39:32]);
      chk_pin(pb_pu, ex[31:24]);
      chk_pin(pc_o & ex[15:8], ex[23:16] & ex[15:8]);
      chk_pin(pc_oe, ex[15:8]);
      chk_pin(pc_pu, ex[7:0]);
      if (arm > 2) begin
        chk_word({28'h0, mi, si, ci, ssn}, {28'h0, ein});
        chk_word({31'h0, act}, {31'h0, sh_ctrl[0] & ~sh_ctrl[1] & ~ein[0]});
      end
    end
  end

  initial begin
    #(5000 * 8);
    fail_count++;
    stop_test();
  end

  initial begin
    logic [31:0] q;
    logic [47:0] e;
    logic [6:0] cfg;
    logic [6:0] tbl [5];
    int i;
    tbl = '{7'h00, 7'h01, 7'h03, 7'h41, 7'h43};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h44, 32'hFF, 4'hF, q);
    wb(1'b0, 8'h40, 32'h0, 4'hF, q);
    chk_word(q, 32'h0);
    for (i = 0; i < 5; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0, 4'hF, q);
      chk_word(q, 32'h0);
    end
    for (i = 0; i < 26; i++) begin
      legacy <= (i >= 13);
      cfg = (i % 13 < 5) ? tbl[i%13] : {rnd[6], 3'(i % 13 - 5), 1'b1, rnd[1:0]};
      wb(1'b1, REG_PB_LATCH, rnd, 4'h1, q);
      wb(1'b1, REG_PB_DIR, rnd, 4'h1, q);
      wb(1'b1, REG_PC_LATCH, rnd, 4'h1, q);
      wb(1'b1, REG_PC_DIR, rnd, 4'h1, q);
      wb(1'b1, REG_CTRL, {25'h0, cfg}, 4'h1, q);
      wb(1'b0, REG_CTRL, 32'h0, 4'hF, q);
      chk_word(q, {25'h0, cfg});
      repeat (16) @(posedge clk_i);
      e = exp_pins();
      wb(1'b0, REG_DIR_STATE, 32'h0, 4'hF, q);
      chk_word(q, {16'h0000, e[15:8], e[39:32]});
      wb(1'b0, REG_PB_PINS, 32'h0, 4'hF, q);
      if (!cfg[0]) chk_word(q & {28'h0, sh_db[3:0]}, {28'h0, sh_lb[3:0] & sh_db[3:0]});
      wb(1'b0, REG_PC_PINS, 32'h0, 4'hF, q);
      if (!cfg[2] && e[15:8] == 8'hFF) chk_word(q, {24'h00_0000, sh_lc});
    end
    wb(1'b1, REG_PB_LATCH, 32'hA5, 4'h1, q);
    wb(1'b1, REG_PB_LATCH, 32'h5A, 4'hE, q);
    wb(1'b0, REG_PB_LATCH, 32'h0, 4'hF, q);
    chk_word(q, 32'hA5);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_CTRL, 32'h0, 4'hF, q);
    chk_word(q, 32'h0);
    stop_test();
  end
endmodule
